// ===== rtl/rsx_alu.sv
/*
 * Combinational arithmetic for the execution block: subtract with
 * borrow in, nibble swap, rotate and xor. Result and flags per op.
 * Assumes operands are stable for the evaluating cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module rsx_alu
    import rsx_pkg::*;
(
    // Operands
    input  wire rsx_op_e           op,
    input  wire logic [DATA_W-1:0] acc,
    input  wire logic [DATA_W-1:0] fval,
    input  wire logic [DATA_W-1:0] literal,
    input  wire logic              carry_in,
    // Results
    output logic [DATA_W-1:0]      result,
    output logic                   carry_out,
    output logic                   dc_out
);
    logic [DATA_W:0]  diff;
    logic [NIB_W:0]   ndiff;
    logic [DATA_W-1:0] minuend;
    logic             borrow;

    always_comb begin
        minuend = (op == OP_SUB_ACC_FROM_LITERAL) ? literal : fval;
        // Borrow is the inverted carry
        borrow = (op == OP_SUB_ACC_FROM_FILE_BORROW) ? ~carry_in : 1'b0;
        diff = {1'b0, minuend} + {1'b0, ~acc} + {{DATA_W{1'b0}}, ~borrow};
        ndiff = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~acc[NIB_W-1:0]}
              + {{NIB_W{1'b0}}, ~borrow};
        result    = diff[DATA_W-1:0];
        carry_out = carry_in;
        dc_out    = 1'b0;
        case (op)
            OP_ROTATE_RIGHT_THRU_CARRY: begin
                result    = {carry_in, fval[DATA_W-1:1]};
                carry_out = fval[0];
            end
            OP_SUB_ACC_FROM_LITERAL,
            OP_SUB_ACC_FROM_FILE,
            OP_SUB_ACC_FROM_FILE_BORROW: begin
                carry_out = diff[DATA_W];
                dc_out    = ndiff[NIB_W];
            end
            OP_SWAP_FILE_NIBBLES:
                result = {fval[NIB_W-1:0], fval[DATA_W-1:NIB_W]};
            OP_XOR_ACC_LITERAL:
                result = acc ^ literal;
            OP_XOR_ACC_FILE:
                result = acc ^ fval;
            default:
                result = diff[DATA_W-1:0];
        endcase
    end
endmodule
`default_nettype wire

// ===== rtl/rsx_exec.sv
/*
 * Execution unit for rotate, subtract, swap, direction load, xor and
 * sleep. Holds accumulator, status flags, port direction registers,
 * watchdog counter and sleep state.
 * Assumes the file register value for faddr is presented combinationally
 * on file_rdata in the cycle the instruction is valid.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Rotate right through carry: carry into bit 7, bit 0 out to carry.
// - Destination bit 0 writes accumulator, 1 writes file register.
// - Literal minus accumulator into accumulator; updates carry, digit carry, zero.
// - File minus accumulator; carry clears when accumulator larger, digit carry when its low nibble is larger.
// - File minus accumulator minus inverted carry; flags updated; destination stored.
// - Swap nibbles of file register into destination; flags unchanged.
// - Accumulator to direction register A, B, C for operand 5, 6, 7.
// - Accumulator xor literal into accumulator; only zero flag changes.
// - Accumulator xor file register to destination; only zero flag changes.
// - Sleep clears powerdown flag, sets timeout flag, clears watchdog and prescaler.
// - After sleep, core halts with oscillator stopped.
module rsx_exec
    import rsx_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // Decoded instruction
    input  wire rsx_instr_s        instr,
    input  wire logic [DATA_W-1:0] file_rdata,
    // Watchdog tick and wake
    input  wire logic              wdog_tick,
    input  wire logic              wake,
    // File register write
    output rsx_fwrite_s            fwrite,
    // Core state
    output logic [DATA_W-1:0]      acc,
    output rsx_status_s            status,
    output logic [DATA_W-1:0]      port_a_direction,
    output logic [DATA_W-1:0]      port_b_direction,
    output logic [DATA_W-1:0]      port_c_direction,
    output logic [DATA_W-1:0]      watchdog_counter,
    output logic [DATA_W-1:0]      watchdog_prescaler,
    output logic                   sleeping,
    output logic                   osc_run
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    logic [DATA_W-1:0] alu_result;
    logic              alu_carry;
    logic              alu_dc;

    rsx_alu u_alu (
        .op        (instr.op),
        .acc       (acc),
        .fval      (file_rdata),
        .literal   (instr.literal),
        .carry_in  (status.carry),
        .result    (alu_result),
        .carry_out (alu_carry),
        .dc_out    (alu_dc)
    );

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == ZERO_BYTE;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    typedef enum logic {RUN, HALT} rsx_run_e;
    rsx_run_e          run_state;
    rsx_run_e          next_run_state;
    logic [DATA_W-1:0] next_acc;
    rsx_status_s       next_status;
    rsx_fwrite_s       next_fwrite;
    logic [DATA_W-1:0] next_dir_a;
    logic [DATA_W-1:0] next_dir_b;
    logic [DATA_W-1:0] next_dir_c;
    logic [DATA_W-1:0] next_wdog;
    logic [DATA_W-1:0] next_presc;
    logic              exec;
    logic              to_dest;

    always_comb begin
        next_run_state = run_state;
        next_acc       = acc;
        next_status    = status;
        next_fwrite    = '{we: 1'b0, addr: instr.faddr, data: alu_result};
        next_dir_a     = port_a_direction;
        next_dir_b     = port_b_direction;
        next_dir_c     = port_c_direction;
        next_wdog      = watchdog_counter;
        next_presc     = watchdog_prescaler;
        exec           = instr.valid && (run_state == RUN);
        to_dest        = 1'b0;
        if (wdog_tick) begin
            {next_wdog, next_presc} = {watchdog_counter, watchdog_prescaler}
                                      + 16'h0001;
        end
        case (run_state)
            HALT: begin
                if (wake) begin
                    next_run_state = RUN;
                end
            end
            default: begin
                next_run_state = RUN;
            end
        endcase
        if (exec) begin
            case (instr.op)
                OP_ROTATE_RIGHT_THRU_CARRY: begin
                    next_status.carry = alu_carry;
                    to_dest = 1'b1;
                end
                OP_SUB_ACC_FROM_LITERAL: begin
                    next_acc = alu_result;
                    next_status.carry = alu_carry;
                    next_status.digit_carry_flag = alu_dc;
                    next_status.zero = is_zero(alu_result);
                end
                OP_SUB_ACC_FROM_FILE,
                OP_SUB_ACC_FROM_FILE_BORROW: begin
                    next_status.carry = alu_carry;
                    next_status.digit_carry_flag = alu_dc;
                    next_status.zero = is_zero(alu_result);
                    to_dest = 1'b1;
                end
                OP_SWAP_FILE_NIBBLES: begin
                    to_dest = 1'b1;
                end
                OP_LOAD_PORT_DIRECTION: begin
                    case (instr.faddr)
                        DIR_SEL_A: next_dir_a = acc;
                        DIR_SEL_B: next_dir_b = acc;
                        DIR_SEL_C: next_dir_c = acc;
                        default: next_dir_a = port_a_direction;
                    endcase
                end
                OP_XOR_ACC_LITERAL: begin
                    next_acc = alu_result;
                    next_status.zero = is_zero(alu_result);
                end
                OP_XOR_ACC_FILE: begin
                    next_status.zero = is_zero(alu_result);
                    to_dest = 1'b1;
                end
                OP_SLEEP: begin
                    next_status.powerdown_status_flag = 1'b0;
                    next_status.timeout_status_flag   = 1'b1;
                    next_wdog  = WDOG_CLEARED;
                    next_presc = PRESC_CLEARED;
                    next_run_state = HALT;
                end
                default: begin
                    next_acc = acc;
                end
            endcase
            if (to_dest) begin
                if (instr.dest == DEST_FILE) begin
                    next_fwrite.we = 1'b1;
                end else begin
                    next_acc = alu_result;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_state          <= RUN;
            acc                <= ZERO_BYTE;
            status             <= '{carry: 1'b0, digit_carry_flag: 1'b0,
                                    zero: 1'b0, timeout_status_flag: 1'b1,
                                    powerdown_status_flag: 1'b1};
            fwrite             <= '0;
            port_a_direction   <= DIR_RESET;
            port_b_direction   <= DIR_RESET;
            port_c_direction   <= DIR_RESET;
            watchdog_counter   <= WDOG_CLEARED;
            watchdog_prescaler <= PRESC_CLEARED;
        end else begin
            run_state          <= next_run_state;
            acc                <= next_acc;
            status             <= next_status;
            fwrite             <= next_fwrite;
            port_a_direction   <= next_dir_a;
            port_b_direction   <= next_dir_b;
            port_c_direction   <= next_dir_c;
            watchdog_counter   <= next_wdog;
            watchdog_prescaler <= next_presc;
        end
    end

    assign sleeping = (run_state == HALT);
    assign osc_run  = (run_state == RUN);
endmodule
`default_nettype wire

// ===== shared/rsx_pkg.sv
/*
 * Package for the rotate/subtract/xor execution block: opcode set,
 * operand widths, port-direction selectors and carried structs.
 * Assumes one core clock domain.
 */
package rsx_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W  = 4;

    localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
    localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
    localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;

    localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RESET    = 8'hff;
    localparam logic [DATA_W-1:0] WDOG_CLEARED = 8'h00;
    localparam logic [DATA_W-1:0] PRESC_CLEARED = 8'h00;

    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ROTATE_RIGHT_THRU_CARRY,
        OP_SUB_ACC_FROM_LITERAL,
        OP_SUB_ACC_FROM_FILE,
        OP_SUB_ACC_FROM_FILE_BORROW,
        OP_SWAP_FILE_NIBBLES,
        OP_LOAD_PORT_DIRECTION,
        OP_XOR_ACC_LITERAL,
        OP_XOR_ACC_FILE,
        OP_SLEEP
    } rsx_op_e;

    // Decoded instruction from the decoder
    typedef struct packed {
        logic              valid;
        rsx_op_e           op;
        logic [ADDR_W-1:0] faddr;
        logic              dest;
        logic [DATA_W-1:0] literal;
    } rsx_instr_s;

    // Status flags held in the core
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
        logic timeout_status_flag;
        logic powerdown_status_flag;
    } rsx_status_s;

    // File register write request
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rsx_fwrite_s;
endpackage

// ===== verif/rsx_exec_properties.sv
/* Checker for the rotate/subtract/xor execution block ports.
   Assumes it is bound into rsx_exec with one core clock. */
`timescale 1ns/1ps
`default_nettype none
module rsx_exec_properties
    import rsx_pkg::*;
(
    // Clock, reset and inputs
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire rsx_instr_s        instr,
    input  wire logic [DATA_W-1:0] file_rdata,
    // Outputs watched
    input  wire rsx_fwrite_s       fwrite,
    input  wire logic [DATA_W-1:0] acc,
    input  wire rsx_status_s       status,
    input  wire logic [DATA_W-1:0] port_a_direction,
    input  wire logic [DATA_W-1:0] watchdog_counter,
    input  wire logic [DATA_W-1:0] watchdog_prescaler,
    input  wire logic              sleeping,
    input  wire logic              osc_run
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    logic go;
    assign go = instr.valid && !sleeping;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_ROTATE: assert property (
        go && instr.op == OP_ROTATE_RIGHT_THRU_CARRY && instr.dest |=>
        fwrite.we && fwrite.data == {$past(status.carry), $past(file_rdata[7:1])}
        && status.carry == $past(file_rdata[0]) && $stable(status.zero))
        else $error("rotate result wrong");
    AST_SUB_LIT: assert property (
        go && instr.op == OP_SUB_ACC_FROM_LITERAL |=>
        acc == $past(instr.literal) - $past(acc) && status.zero == (acc == 0)
        && status.carry == ($past(acc) <= $past(instr.literal)))
        else $error("literal subtract wrong");
    AST_SUB_FILE: assert property (
        go && instr.op == OP_SUB_ACC_FROM_FILE && !instr.dest |=>
        acc == $past(file_rdata) - $past(acc) && !fwrite.we
        && status.digit_carry_flag == ($past(acc[3:0]) <= $past(file_rdata[3:0])))
        else $error("file subtract wrong");
    AST_SWAP: assert property (
        go && instr.op == OP_SWAP_FILE_NIBBLES |=> $stable(status))
        else $error("swap changed flags");
    AST_DIR_A: assert property (
        go && instr.op == OP_LOAD_PORT_DIRECTION && instr.faddr == DIR_SEL_A |=>
        port_a_direction == $past(acc) && $stable(status))
        else $error("direction A load wrong");
    AST_XOR_LIT: assert property (
        go && instr.op == OP_XOR_ACC_LITERAL |=>
        acc == ($past(acc) ^ $past(instr.literal)) && status.zero == (acc == 0)
        && $stable(status.carry) && $stable(status.digit_carry_flag))
        else $error("xor literal wrong");
    AST_XOR_FILE: assert property (
        go && instr.op == OP_XOR_ACC_FILE && instr.dest |=> fwrite.we
        && fwrite.data == ($past(acc) ^ $past(file_rdata)) && $stable(acc))
        else $error("xor file wrong");
    AST_SLEEP: assert property (
        go && instr.op == OP_SLEEP |=> sleeping && status.timeout_status_flag
        && !status.powerdown_status_flag && watchdog_counter == WDOG_CLEARED
        && watchdog_prescaler == PRESC_CLEARED)
        else $error("sleep side effects wrong");
    AST_HALT: assert property (
        sleeping |-> !osc_run ##1 $stable(acc) && $stable(port_a_direction))
        else $error("halt not kept");
endmodule
bind rsx_exec rsx_exec_properties i_props (.sys_clk(sys_clk),
    .arst_n(arst_n), .instr(instr), .file_rdata(file_rdata),
    .fwrite(fwrite), .acc(acc), .status(status),
    .port_a_direction(port_a_direction), .watchdog_counter(watchdog_counter),
    .watchdog_prescaler(watchdog_prescaler), .sleeping(sleeping),
    .osc_run(osc_run));
`default_nettype wire

// ===== verif/rsx_exec_tb.sv
/* Self-checking bench for rsx_exec: corner cases then random ops.
   Assumes rsx_pkg and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module rsx_exec_tb;
    import rsx_pkg::*;
    // ----------------------------------------
    // Signals and expected state
    // ----------------------------------------
    logic              sys_clk, arst_n, wdog_tick, wake, sleeping, osc_run;
    rsx_instr_s        instr;
    logic [DATA_W-1:0] file_rdata, acc, dir_a, dir_b, dir_c, wd_cnt, wd_pre;
    rsx_fwrite_s       fwrite;
    rsx_status_s       status;
    int                failures, samples_checked;
    logic [DATA_W-1:0] m_acc, m_dir [3];
    logic [15:0]       m_wd;
    logic              m_c, m_dc, m_z, m_to, m_pd, m_sl;
    rsx_exec i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .instr(instr),
        .file_rdata(file_rdata), .wdog_tick(wdog_tick), .wake(wake),
        .fwrite(fwrite), .acc(acc), .status(status),
        .port_a_direction(dir_a), .port_b_direction(dir_b),
        .port_c_direction(dir_c), .watchdog_counter(wd_cnt),
        .watchdog_prescaler(wd_pre), .sleeping(sleeping), .osc_run(osc_run));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [9:0] sub(logic [7:0] a, logic [7:0] b, logic ci);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, ~b} + 9'(ci);
        n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
        return {s[8], n[4], s[7:0]};
    endfunction
    task automatic step(rsx_op_e op, logic [6:0] fa, logic d, logic [7:0] k,
                        logic [7:0] f, logic tk, logic wk);
        logic [9:0] s;
        logic       ew;
        s = {m_c, m_dc, m_acc};
        ew = 1'b0;
        instr = '{1'b1, op, fa, d, k};
        file_rdata = f;
        wdog_tick = tk & !m_sl;
        wake = wk;
        if (m_sl) begin
            m_sl = !wk;
        end else begin
            case (op)
                OP_ROTATE_RIGHT_THRU_CARRY:  s = {f[0], m_dc, m_c, f[7:1]};
                OP_SUB_ACC_FROM_LITERAL:     s = sub(k, m_acc, 1'b1);
                OP_SUB_ACC_FROM_FILE:        s = sub(f, m_acc, 1'b1);
                OP_SUB_ACC_FROM_FILE_BORROW: s = sub(f, m_acc, m_c);
                OP_SWAP_FILE_NIBBLES:        s = {m_c, m_dc, f[3:0], f[7:4]};
                OP_XOR_ACC_LITERAL:          s = {m_c, m_dc, m_acc ^ k};
                OP_XOR_ACC_FILE:             s = {m_c, m_dc, m_acc ^ f};
                default: ;
            endcase
            if (op == OP_LOAD_PORT_DIRECTION && fa inside {[5:7]})
                m_dir[fa - 7'd5] = m_acc;
            m_wd = (op == OP_SLEEP) ? 16'h0000 : m_wd + 16'(tk);
            ew = d && op inside {OP_ROTATE_RIGHT_THRU_CARRY, OP_SWAP_FILE_NIBBLES,
                 OP_SUB_ACC_FROM_FILE, OP_SUB_ACC_FROM_FILE_BORROW, OP_XOR_ACC_FILE};
            if (op inside {OP_SUB_ACC_FROM_LITERAL, OP_SUB_ACC_FROM_FILE,
                 OP_SUB_ACC_FROM_FILE_BORROW, OP_XOR_ACC_LITERAL, OP_XOR_ACC_FILE})
                m_z = (s[7:0] == ZERO_BYTE);
            if (!ew && !(op inside {OP_NONE, OP_LOAD_PORT_DIRECTION, OP_SLEEP}))
                m_acc = s[7:0];
            {m_c, m_dc} = s[9:8];
            if (op == OP_SLEEP) {m_to, m_pd, m_sl} = 3'b101;
        end
        @(negedge sys_clk);
        chk("acc", 24'(acc), 24'(m_acc));
        chk("status", 24'(status), 24'({m_c, m_dc, m_z, m_to, m_pd}));
        chk("fw_we", 24'(fwrite.we), 24'(ew));
        if (ew) chk("fw", 24'({fwrite.addr, fwrite.data}), 24'({fa, s[7:0]}));
        chk("dir", {dir_a, dir_b, dir_c}, {m_dir[0], m_dir[1], m_dir[2]});
        chk("wdog", 24'({wd_cnt, wd_pre}), 24'(m_wd));
        chk("halt", 24'({sleeping, osc_run}), 24'({m_sl, !m_sl}));
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {arst_n, wdog_tick, wake, instr, file_rdata} = '0;
        {failures, samples_checked, m_acc, m_wd, m_c, m_dc, m_z, m_sl} = '0;
        {m_to, m_pd} = 2'b11;
        m_dir = '{DIR_RESET, DIR_RESET, DIR_RESET};
        void'($urandom(12));
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        step(OP_XOR_ACC_LITERAL, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
        step(OP_XOR_ACC_LITERAL, 7'h00, 1'b0, 8'h3c, 8'h00, 1'b0, 1'b0);
        step(OP_SUB_ACC_FROM_LITERAL, 7'h00, 1'b0, 8'h3c, 8'h00, 1'b0, 1'b0);
        step(OP_XOR_ACC_LITERAL, 7'h00, 1'b0, 8'h03, 8'h00, 1'b0, 1'b0);
        step(OP_SUB_ACC_FROM_FILE, 7'h20, 1'b1, 8'h00, 8'h10, 1'b0, 1'b0);
        step(OP_SUB_ACC_FROM_FILE, 7'h21, 1'b0, 8'h00, 8'h02, 1'b0, 1'b0);
        step(OP_SUB_ACC_FROM_FILE_BORROW, 7'h22, 1'b0, 8'h00, 8'h05, 1'b0, 1'b0);
        step(OP_ROTATE_RIGHT_THRU_CARRY, 7'h23, 1'b1, 8'h00, 8'h81, 1'b0, 1'b0);
        step(OP_ROTATE_RIGHT_THRU_CARRY, 7'h23, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0);
        step(OP_SWAP_FILE_NIBBLES, 7'h24, 1'b0, 8'h00, 8'ha5, 1'b0, 1'b0);
        for (int i = 4; i <= 8; i++) begin
            step(OP_LOAD_PORT_DIRECTION, 7'(i), 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
        end
        step(OP_XOR_ACC_FILE, 7'h25, 1'b1, 8'h00, 8'h5a, 1'b0, 1'b0);
        step(OP_NONE, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
        step(OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
        step(OP_XOR_ACC_LITERAL, 7'h00, 1'b0, 8'hff, 8'h00, 1'b0, 1'b0);
        step(OP_XOR_ACC_LITERAL, 7'h00, 1'b0, 8'hff, 8'h00, 1'b0, 1'b1);
        step(OP_XOR_ACC_LITERAL, 7'h00, 1'b0, 8'hff, 8'h00, 1'b0, 1'b0);
        repeat (400) begin
            step(rsx_op_e'($urandom_range(0, 9)), 7'($urandom_range(4, 8)),
                 1'($urandom), 8'($urandom), 8'($urandom), 1'($urandom),
                 1'($urandom));
        end
        instr.valid = 1'b0;
        final_report();
    end
endmodule
`default_nettype wire
